// [dv/ep_fifo_props.sv]
// Assertions on the link between the master and device ends.
// Assumes one clock and ce held high; the bench instantiates it.
`timescale 1ns/1ps
module ep_fifo_props
	import ep_fifo_pkg::*;
(
	input wire logic                       clock,
	input wire logic                       sys_rst,
	input wire logic                       cfgWrite,
	input wire logic [ep_fifo_pkg::SIZE_W-1:0] cfgMaxSize,
	input wire logic                       cfgDirect,
	input wire logic                       cfgTx,
	input wire logic                       cbWrite,
	input wire logic [ep_fifo_pkg::BE_W-1:0]   commonBusByteEnable,
	input wire logic                       dpWrite,
	input wire logic [ep_fifo_pkg::BE_W-1:0]   directPortWriteByteEnable,
	input wire logic                       cmdValid,
	input wire ep_fifo_pkg::cmd_t          cmdCode,
	input wire logic                       writeReady,
	input wire logic                       sizeError,
	input wire logic                       packetDone
);
	logic [SIZE_W-1:0] size_reg, size_next, count_reg, count_next, step;
	import ep_fifo_pkg::*;

	logic              dir_reg, dir_next, oddDirect, selWr, eopCmd;
	logic [BE_W-1:0]   selBe;

	// Shadow of the accepted size and bytes taken into the open buffer
	always_comb
	begin
		oddDirect = cfgDirect && cfgTx && cfgMaxSize[0];
		// Only end-of-packet is barred after a full packet; clear is not
		eopCmd = cmdValid && cmdCode == CMD_EOP;
		selBe = dir_reg ? directPortWriteByteEnable : commonBusByteEnable;
		selWr = writeReady && (dir_reg ? dpWrite : cbWrite);
		step = '0;
		if (selWr && selBe == BE_BOTH)
			step = 11'h002;
		if (selWr && selBe == BE_LOW)
			step = 11'h001;
		count_next = (packetDone ? '0 : count_reg) + step;
		size_next = size_reg;
		dir_next = dir_reg;
		if (cfgWrite || cmdValid)
			count_next = '0;
		if (cfgWrite && !oddDirect)
		begin
			size_next = cfgMaxSize;
			dir_next = cfgDirect;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			size_reg <= SIZE_RESET;
			dir_reg <= 1'b0;
			count_reg <= '0;
		end
		else
		begin
			size_reg <= size_next;
			dir_reg <= dir_next;
			count_reg <= count_next;
		end
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	sequence lowTail;
		selWr && selBe == BE_LOW && !cfgWrite && !cmdValid;
	endsequence
	sequence fullDone;
		packetDone && !$past(cmdValid);
	endsequence
	sequence disableCmd;
		cmdValid && cmdCode == CMD_DISABLE;
	endsequence

	odd_refused_a: assert property (cfgWrite && oddDirect |=> sizeError)
		else $error("odd direct transmit size not refused");
	even_direct_a: assert property (cfgWrite |-> !oddDirect)
		else $error("odd size sent for a direct transmit endpoint");
	size_taken_a: assert property (cfgWrite && !oddDirect |=> !sizeError)
		else $error("legal size flagged as error");
	error_holds_a: assert property (!cfgWrite |=> $stable(sizeError))
		else $error("size error changed without a config write");
	done_pulse_a: assert property (packetDone |=> !packetDone)
		else $error("packet done longer than one cycle");
	full_count_a: assert property (fullDone |-> count_reg == size_reg)
		else $error("packet done at wrong byte count");
	no_eop_full_a: assert property (fullDone |-> !eopCmd[*3])
		else $error("end of packet sent after a full packet");
	eop_closes_a: assert property (cmdValid && cmdCode == CMD_EOP |=> packetDone)
		else $error("end of packet did not close the buffer");
	low_tail_a: assert property (lowTail |=> !writeReady || packetDone)
		else $error("writes still taken after a low-lane byte");
	disable_holds_a: assert property (disableCmd |=> !writeReady[*4])
		else $error("disabled endpoint still ready");
endmodule

// [dv/usb_ep_packet_size_fifo_access_tb_top.sv]
// Bench joining master and device; a second device faces a rogue driver.
// Assumes package, interface and both design modules compiled first.
`timescale 1ns/1ps
module usb_ep_packet_size_fifo_access_tb_top;
	import ep_fifo_pkg::*;
	localparam int FRAME_T = 50;
	logic              clock, sys_rst, ceOn, cfgStart, userDirect, userDual;
	logic              userIso, sendStart, clearStart, disableStart, pktTaken;
	logic              dataTake, busy, pktReady, epEnabled, frameStart;
	logic [SIZE_W-1:0] userMaxSize, sendLength, pktLength, descriptorSize;
	logic [DATA_W-1:0] dataIn, readData;
	logic [WIDX_W-1:0] readAddr;
	logic [8:0]        wordIdx;
	int                n_mismatch, num_checks;
	ep_fifo_if link();
	ep_fifo_if bad();

	ep_fifo_master ep_fifo_master_i (.clock(clock), .sys_rst(sys_rst),
		.ce(ceOn), .link(link), .cfgStart(cfgStart), .userMaxSize(userMaxSize),
		.userDirect(userDirect), .userDual(userDual), .userIso(userIso),
		.sendStart(sendStart), .sendLength(sendLength), .dataIn(dataIn),
		.clearStart(clearStart), .disableStart(disableStart),
		.dataTake(dataTake), .busy(busy), .descriptorSize(descriptorSize));
	ep_fifo_device #(.FRAME_CYCLES(FRAME_T)) ep_fifo_device_i (.clock(clock),
		.sys_rst(sys_rst), .ce(ceOn), .link(link), .pktTaken(pktTaken),
		.readAddr(readAddr), .pktReady(pktReady), .pktLength(pktLength),
		.readData(readData), .epEnabled(epEnabled), .frameStart(frameStart));
	ep_fifo_device #(.FRAME_CYCLES(FRAME_T)) ep_fifo_device_i2 (.clock(clock),
		.sys_rst(sys_rst), .ce(ceOn), .link(bad), .pktTaken(pktTaken),
		.readAddr(readAddr), .pktReady(), .pktLength(), .readData(),
		.epEnabled(), .frameStart());
	ep_fifo_props ep_fifo_props_i (.clock(clock), .sys_rst(sys_rst),
		.cfgWrite(link.cfgWrite), .cfgMaxSize(link.cfgMaxSize),
		.cfgDirect(link.cfgDirect), .cfgTx(link.cfgTx),
		.cbWrite(link.cbWrite), .commonBusByteEnable(link.commonBusByteEnable),
		.dpWrite(link.dpWrite),
		.directPortWriteByteEnable(link.directPortWriteByteEnable),
		.cmdValid(link.cmdValid), .cmdCode(link.cmdCode),
		.writeReady(link.writeReady), .sizeError(link.sizeError),
		.packetDone(link.packetDone));

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Byte n of a packet carries the value n, low lane first
	assign dataIn = {8'(2 * wordIdx + 1), 8'(2 * wordIdx)};
	// One process owns the byte counter; a send restarts it at byte 0
	always @(posedge clock)
		if (sendStart === 1'b1)
			wordIdx <= 9'h000;
		else if (dataTake === 1'b1)
			wordIdx <= wordIdx + 9'h001;

	task automatic tick();
		@(posedge clock);
		#1;
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Bounded wait: 0 pktReady, 1 busy, 2 frameStart
	task automatic wait_sig(input int which, input logic lvl);
		int i;
		logic cur;
		cur = ~lvl;
		for (i = 0; i < 3000 && cur !== lvl; i++)
		begin
			tick();
			cur = (which == 0) ? pktReady : (which == 1) ? busy : frameStart;
		end
		if (cur !== lvl)
		begin
			n_mismatch++;
			complete_run();
		end
	endtask

	task automatic configure(input logic [10:0] sz, input logic dir, iso);
		userMaxSize = sz;
		userDirect = dir;
		userDual = iso;
		userIso = iso;
		cfgStart = 1'b1;
		tick();
		cfgStart = 1'b0;
		repeat (3) tick();
	endtask

	task automatic send(input logic [10:0] len);
		sendLength = len;
		sendStart = 1'b1;
		tick();
		sendStart = 1'b0;
		wait_sig(1, 1'b0);
		wait_sig(0, 1'b1);
	endtask

	task automatic take();
		pktTaken = 1'b1;
		tick();
		pktTaken = 1'b0;
		tick();
	endtask

	task automatic read_check(input int nBytes);
		int i;
		logic [15:0] exp;
		for (i = 0; i < (nBytes + 1) / 2; i++)
		begin
			readAddr = WIDX_W'(i);
			tick();
			exp = {8'(2 * i + 1), 8'(2 * i)};
			if (2 * i + 1 == nBytes)
				check({8'h00, readData[7:0]}, {8'h00, exp[7:0]});
			else
				check(readData, exp);
		end
		take();
	endtask

	// Rogue master: drives a config on the second link, including an odd direct size the master never would
	task automatic rogue_cfg(input logic [10:0] sz, input logic dir, err);
		bad.cfgMaxSize = sz;
		bad.cfgDirect = dir;
		bad.cfgWrite = 1'b1;
		tick();
		bad.cfgWrite = 1'b0;
		tick();
		check(16'(bad.sizeError), 16'(err));
	endtask

	initial
	begin
		int i;
		{sys_rst, ceOn, cfgStart, userDirect, userDual, userIso} = 6'h30;
		{sendStart, clearStart, disableStart, pktTaken} = 4'h0;
		{userMaxSize, sendLength, readAddr} = '0;
		{bad.cfgWrite, bad.cfgDirect, bad.cfgDual, bad.cfgIso} = 4'h0;
		{bad.cbWrite, bad.dpWrite, bad.cmdValid, bad.cfgTx} = 4'h1;
		{bad.cfgMaxSize, bad.cbData, bad.dpData} = '0;
		bad.commonBusByteEnable = BE_BOTH;
		bad.directPortWriteByteEnable = BE_BOTH;
		bad.cmdCode = CMD_NONE;
		n_mismatch = 0;
		num_checks = 0;
		repeat (16) tick();
		sys_rst = 1'b0;
		check(16'(descriptorSize), 16'h0040);
		check(16'(link.writeReady), 16'h0000);
		configure(11'h005, 1'b0, 1'b0);
		check(16'(link.sizeError), 16'h0000);
		send(11'h005);
		check(16'(pktLength), 16'h0005);
		read_check(5);
		send(11'h003);
		check(16'(pktLength), 16'h0003);
		read_check(3);
		configure(11'h3ff, 1'b1, 1'b0);
		check(16'(link.sizeError), 16'h0000);
		check(16'(descriptorSize), 16'h03ff);
		send(11'h3ff);
		check(16'(pktLength), 16'h03ff);
		read_check(1023);
		rogue_cfg(11'h005, 1'b1, 1'b1);
		rogue_cfg(11'h005, 1'b0, 1'b0);
		rogue_cfg(11'h006, 1'b1, 1'b0);
		configure(11'h004, 1'b0, 1'b1);
		send(11'h004);
		send(11'h004);
		check(16'(link.writeReady), 16'h0000);
		wait_sig(2, 1'b1);
		tick();
		take();
		check(16'(pktReady), 16'h0001);
		take();
		check(16'(pktReady), 16'h0001);
		wait_sig(2, 1'b1);
		tick();
		take();
		check(16'(pktReady), 16'h0000);
		// Count from a frame start, so the gap is one full period
		wait_sig(2, 1'b1);
		for (i = 1; i < 200; i++)
		begin
			tick();
			if (frameStart === 1'b1)
				break;
		end
		check(16'(i), 16'(FRAME_T));
		send(11'h004);
		clearStart = 1'b1;
		tick();
		clearStart = 1'b0;
		repeat (2) tick();
		check(16'(pktReady), 16'h0000);
		disableStart = 1'b1;
		tick();
		disableStart = 1'b0;
		repeat (3) tick();
		check(16'({epEnabled, link.writeReady}), 16'h0000);
		complete_run();
	end
endmodule

// [pkg/ep_fifo_if.sv]
// Link between the endpoint FIFO and the master that fills it.
// Both ends run on the same clock; the bench joins them here.
`timescale 1ns/1ps
interface ep_fifo_if;
	import ep_fifo_pkg::*;

	logic               cfgWrite;
	logic [SIZE_W-1:0]  cfgMaxSize;
	logic               cfgDirect;
	logic               cfgDual;
	logic               cfgTx;
	logic               cfgIso;
	logic               cbWrite;
	logic [DATA_W-1:0]  cbData;
	logic [BE_W-1:0]    commonBusByteEnable;
	logic               dpWrite;
	logic [DATA_W-1:0]  dpData;
	logic [BE_W-1:0]    directPortWriteByteEnable;
	logic               cmdValid;
	cmd_t               cmdCode;
	logic               writeReady;
	logic               sizeError;
	logic               packetDone;

	modport device (
		input  cfgWrite, cfgMaxSize, cfgDirect, cfgDual, cfgTx, cfgIso,
		input  cbWrite, cbData, commonBusByteEnable,
		input  dpWrite, dpData, directPortWriteByteEnable,
		input  cmdValid, cmdCode,
		output writeReady, sizeError, packetDone
	);

	modport master (
		output cfgWrite, cfgMaxSize, cfgDirect, cfgDual, cfgTx, cfgIso,
		output cbWrite, cbData, commonBusByteEnable,
		output dpWrite, dpData, directPortWriteByteEnable,
		output cmdValid, cmdCode,
		input  writeReady, sizeError, packetDone
	);

endinterface

// [pkg/ep_fifo_pkg.sv]
// Shared constants and types for the endpoint FIFO write side.
// Assumes a 20 MHz clock and one transmit endpoint per instance.
package ep_fifo_pkg;

	localparam int DATA_W   = 16;
	localparam int SIZE_W   = 11;
	localparam int BE_W     = 2;
	// 2048 bytes of RAM: two 1024-byte buffers of 16-bit words
	localparam int FIFO_BYTES = 2048;
	localparam int MEM_WORDS  = FIFO_BYTES / 2;
	localparam int BUF_WORDS  = MEM_WORDS / 2;
	localparam int WIDX_W     = 9;
	localparam int MIDX_W     = 10;
	localparam logic [SIZE_W-1:0] ISO_MAX_PAYLOAD = 11'h3ff;
	localparam logic [SIZE_W-1:0] SIZE_RESET      = 11'h040;

	localparam logic [BE_W-1:0] BE_LOW  = 2'h1;
	localparam logic [BE_W-1:0] BE_BOTH = 2'h3;

	localparam int CLK_KHZ  = 20000;
	localparam int FRAME_MS = 1;
	localparam int FRAME_CYCLES_DEF = FRAME_MS * CLK_KHZ;
	localparam int FRAME_W  = 16;

	typedef enum logic [1:0] {
		CMD_NONE    = 2'h0,
		CMD_EOP     = 2'h1,
		CMD_CLEAR   = 2'h2,
		CMD_DISABLE = 2'h3
	} cmd_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_CONFIG = 3'h1,
		ST_WRITE  = 3'h2,
		ST_EOP    = 3'h3,
		ST_CMD    = 3'h4
	} mst_state_t;

endpackage

// [rtl/ep_fifo_device.sv]
// Endpoint FIFO write side: size register, packet counting, storage.
// Assumes the master keeps its own rules; drain side is user logic.
// Operation
// - FIFO stores whole byte pairs only
// - Software programs even maximum sizes normally
// - Control and bulk use even sizes only
// - Direct-port transmit refuses odd size setting
// - Last odd byte on common bus uses 01
// - No end-of-packet after full-size packet
// - Odd 1023 direct: program 1024, write 1023
// - Last byte on direct port uses 01
// - Descriptor reports true odd size 1023
// - Port select and single/dual buffering configurable
// - Isochronous uses direct port, dual buffers
// - Dual 1023-byte buffers need 2048 bytes
// - Isochronous: one transaction per 1 ms frame
// - Iso: only clear or disable commands; the master still sends EOP after a short iso packet
// - Iso on common bus closes with EOP
`timescale 1ns/1ps
module ep_fifo_device
	import ep_fifo_pkg::*;
#(
	parameter int FRAME_CYCLES = ep_fifo_pkg::FRAME_CYCLES_DEF
)(
	input  wire logic                            clock,
	input  wire logic                            sys_rst,
	input  wire logic                            ce,
	ep_fifo_if.device                            link,
	input  wire logic                            pktTaken,
	input  wire logic [ep_fifo_pkg::WIDX_W-1:0]  readAddr,
	output logic                                 pktReady,
	output logic      [ep_fifo_pkg::SIZE_W-1:0]  pktLength,
	output logic      [ep_fifo_pkg::DATA_W-1:0]  readData,
	output logic                                 epEnabled,
	output logic                                 frameStart
);
	import ep_fifo_pkg::*;

	logic [SIZE_W-1:0]  ep_max_size_reg, ep_max_size_next;
	logic               directReg, directNext;
	logic               dualReg, dualNext;
	logic               txReg, txNext;
	logic               isoReg, isoNext;
	logic               enabledReg, enabledNext;
	logic               sizeErrReg, sizeErrNext;
	cmd_t               controller_command_reg, controller_command_next;
	logic [SIZE_W-1:0]  cntReg [2];
	logic [SIZE_W-1:0]  cntNext [2];
	logic [1:0]         fullReg, fullNext;
	logic               wSelReg, wSelNext;
	logic               rSelReg, rSelNext;
	logic               oddReg, oddNext;
	logic               doneReg, doneNext;
	logic               frameUsedReg, frameUsedNext;
	logic [FRAME_W-1:0] frameCntReg, frameCntNext;
	logic               frameTickReg, frameTickNext;
	logic [DATA_W-1:0]  rdReg, rdNext;
	logic [DATA_W-1:0]  mem [MEM_WORDS];
	logic               memWe;
	logic [MIDX_W-1:0]  memAddr;
	logic [DATA_W-1:0]  memData;

	logic               wr;
	logic [BE_W-1:0]    be;
	logic [DATA_W-1:0]  wData;
	logic               accept;
	logic [SIZE_W-1:0]  curCount;
	logic [SIZE_W-1:0]  newCount;
	logic               take;
	logic               sizeOk;

	// Configuration and command register
	always_comb
	begin
		ep_max_size_next        = ep_max_size_reg;
		directNext              = directReg;
		dualNext                = dualReg;
		txNext                  = txReg;
		isoNext                 = isoReg;
		enabledNext             = enabledReg;
		sizeErrNext             = sizeErrReg;
		controller_command_next = controller_command_reg;
		sizeOk = !(link.cfgDirect && link.cfgTx && link.cfgMaxSize[0]);
		if (link.cfgWrite)
		begin
			sizeErrNext = !sizeOk;
			if (sizeOk)
			begin
				ep_max_size_next = link.cfgMaxSize;
				directNext       = link.cfgDirect;
				dualNext         = link.cfgDual;
				txNext           = link.cfgTx;
				isoNext          = link.cfgIso;
				enabledNext      = 1'b1;
			end
		end
		if (link.cmdValid)
		begin
			controller_command_next = link.cmdCode;
			if (link.cmdCode == CMD_DISABLE)
				enabledNext = 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			ep_max_size_reg        <= SIZE_RESET;
			directReg              <= 1'b0;
			dualReg                <= 1'b0;
			txReg                  <= 1'b1;
			isoReg                 <= 1'b0;
			enabledReg             <= 1'b0;
			sizeErrReg             <= 1'b0;
			controller_command_reg <= CMD_NONE;
		end
		else if (ce)
		begin
			ep_max_size_reg        <= ep_max_size_next;
			directReg              <= directNext;
			dualReg                <= dualNext;
			txReg                  <= txNext;
			isoReg                 <= isoNext;
			enabledReg             <= enabledNext;
			sizeErrReg             <= sizeErrNext;
			controller_command_reg <= controller_command_next;
		end
	end

	// Packet counting and buffer hand-off
	always_comb
	begin
		wr    = directReg ? link.dpWrite : link.cbWrite;
		be    = directReg ? link.directPortWriteByteEnable
		                  : link.commonBusByteEnable;
		wData = directReg ? link.dpData : link.cbData;
		curCount = cntReg[wSelReg];
		// After a lone low byte the pair is broken; wait for closing
		accept = wr && enabledReg && txReg && !fullReg[wSelReg] && !oddReg
		         && (be == BE_BOTH || be == BE_LOW);
		newCount = curCount + ((be == BE_BOTH) ? 11'h002 : 11'h001);
		take = pktTaken && pktReady && !(isoReg && frameUsedReg);
		cntNext       = cntReg;
		fullNext      = fullReg;
		wSelNext      = wSelReg;
		rSelNext      = rSelReg;
		oddNext       = oddReg;
		doneNext      = 1'b0;
		frameUsedNext = frameTickReg ? 1'b0 : frameUsedReg;
		memWe   = accept;
		memAddr = {wSelReg, curCount[SIZE_W-2:1]};
		memData = (be == BE_LOW) ? {8'h00, wData[7:0]} : wData;
		if (take)
		begin
			fullNext[rSelReg] = 1'b0;
			cntNext[rSelReg]  = 11'h000;
			rSelNext          = dualReg ? !rSelReg : 1'b0;
			frameUsedNext     = isoReg;
		end
		if (accept)
		begin
			cntNext[wSelReg] = newCount;
			oddNext = (be == BE_LOW);
			if (newCount >= ep_max_size_reg)
			begin
				fullNext[wSelReg] = 1'b1;
				wSelNext = dualReg ? !wSelReg : 1'b0;
				oddNext  = 1'b0;
				doneNext = 1'b1;
			end
		end
		else if (link.cmdValid && link.cmdCode == CMD_EOP
		         && enabledReg && !fullReg[wSelReg])
		begin
			fullNext[wSelReg] = 1'b1;
			wSelNext = dualReg ? !wSelReg : 1'b0;
			oddNext  = 1'b0;
			doneNext = 1'b1;
		end
		if ((link.cmdValid && link.cmdCode == CMD_CLEAR) || link.cfgWrite)
		begin
			cntNext[0] = 11'h000;
			cntNext[1] = 11'h000;
			fullNext   = 2'h0;
			wSelNext   = 1'b0;
			rSelNext   = 1'b0;
			oddNext    = 1'b0;
			doneNext   = 1'b0;
			memWe      = 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			cntReg[0]    <= 11'h000;
			cntReg[1]    <= 11'h000;
			fullReg      <= 2'h0;
			wSelReg      <= 1'b0;
			rSelReg      <= 1'b0;
			oddReg       <= 1'b0;
			doneReg      <= 1'b0;
			frameUsedReg <= 1'b0;
		end
		else if (ce)
		begin
			cntReg       <= cntNext;
			fullReg      <= fullNext;
			wSelReg      <= wSelNext;
			rSelReg      <= rSelNext;
			oddReg       <= oddNext;
			doneReg      <= doneNext;
			frameUsedReg <= frameUsedNext;
		end
	end

	// Frame timer and read port
	always_comb
	begin
		frameTickNext = (frameCntReg == FRAME_W'(FRAME_CYCLES - 1));
		frameCntNext  = frameTickNext ? '0 : frameCntReg + 16'h0001;
		rdNext        = mem[{rSelReg, readAddr}];
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			frameCntReg  <= '0;
			frameTickReg <= 1'b0;
			rdReg        <= 16'h0000;
		end
		else if (ce)
		begin
			frameCntReg  <= frameCntNext;
			frameTickReg <= frameTickNext;
			rdReg        <= rdNext;
		end
	end

	// Storage has no reset; contents are only valid up to the count
	always_ff @(posedge clock)
	begin
		if (ce && memWe)
			mem[memAddr] <= memData;
	end

	assign link.writeReady = enabledReg && txReg && !fullReg[wSelReg]
	                         && !oddReg;
	assign link.sizeError  = sizeErrReg;
	assign link.packetDone = doneReg;
	assign pktReady   = fullReg[rSelReg];
	assign pktLength  = cntReg[rSelReg];
	assign readData   = rdReg;
	assign epEnabled  = enabledReg;
	assign frameStart = frameTickReg;

endmodule

// [rtl/ep_fifo_master.sv]
// Master end: programs the endpoint and writes packets into it.
// Assumes the device end on the same clock; data comes from the user.
`timescale 1ns/1ps
module ep_fifo_master
	import ep_fifo_pkg::*;
(
	input  wire logic                            clock,
	input  wire logic                            sys_rst,
	input  wire logic                            ce,
	ep_fifo_if.master                            link,
	input  wire logic                            cfgStart,
	input  wire logic [ep_fifo_pkg::SIZE_W-1:0]  userMaxSize,
	input  wire logic                            userDirect,
	input  wire logic                            userDual,
	input  wire logic                            userIso,
	input  wire logic                            sendStart,
	input  wire logic [ep_fifo_pkg::SIZE_W-1:0]  sendLength,
	input  wire logic [ep_fifo_pkg::DATA_W-1:0]  dataIn,
	input  wire logic                            clearStart,
	input  wire logic                            disableStart,
	output logic                                 dataTake,
	output logic                                 busy,
	output logic      [ep_fifo_pkg::SIZE_W-1:0]  descriptorSize
);
	import ep_fifo_pkg::*;

	mst_state_t        stateReg, stateNext;
	logic [SIZE_W-1:0] mpsReg, mpsNext;
	logic [SIZE_W-1:0] hwSizeReg, hwSizeNext;
	logic              directReg, directNext;
	logic [SIZE_W-1:0] remReg, remNext;
	logic              shortReg, shortNext;
	cmd_t              cmdReg, cmdNext;
	logic              cmdValidReg, cmdValidNext;
	logic              cfgWrReg, cfgWrNext;
	logic              cfgDualReg, cfgDualNext;
	logic              cfgIsoReg, cfgIsoNext;
	logic              wrReg, wrNext;
	logic [BE_W-1:0]   beReg, beNext;
	logic [DATA_W-1:0] dataReg, dataNext;
	logic [SIZE_W-1:0] len;

	always_comb
	begin
		stateNext    = stateReg;
		mpsNext      = mpsReg;
		hwSizeNext   = hwSizeReg;
		directNext   = directReg;
		remNext      = remReg;
		shortNext    = shortReg;
		cmdNext      = cmdReg;
		cmdValidNext = 1'b0;
		cfgWrNext    = 1'b0;
		cfgDualNext  = cfgDualReg;
		cfgIsoNext   = cfgIsoReg;
		wrNext       = 1'b0;
		beNext       = beReg;
		dataNext     = dataReg;
		dataTake     = 1'b0;
		// Never more than the true size, so 1024 is never reached
		len = (sendLength > mpsReg) ? mpsReg : sendLength;
		case (stateReg)
			ST_IDLE:
			begin
				if (clearStart || disableStart)
				begin
					cmdNext      = clearStart ? CMD_CLEAR : CMD_DISABLE;
					cmdValidNext = 1'b1;
					stateNext    = ST_CMD;
				end
				else if (cfgStart)
				begin
					mpsNext    = userMaxSize;
					directNext = userDirect || userIso;
					hwSizeNext = userMaxSize + {10'h000,
					             (userDirect || userIso) & userMaxSize[0]};
					cfgDualNext = userDual || userIso;
					cfgIsoNext  = userIso;
					cfgWrNext   = 1'b1;
					stateNext   = ST_CONFIG;
				end
				else if (sendStart)
				begin
					remNext   = len;
					shortNext = (len < hwSizeReg);
					stateNext = (len == 11'h000) ? ST_EOP : ST_WRITE;
				end
			end
			ST_CONFIG:
				stateNext = ST_IDLE;
			ST_WRITE:
			begin
				if (link.writeReady && !wrReg)
				begin
					wrNext   = 1'b1;
					dataTake = 1'b1;
					dataNext = dataIn;
					beNext   = (remReg >= 11'h002) ? BE_BOTH : BE_LOW;
					remNext  = (remReg >= 11'h002) ? remReg - 11'h002 : 11'h000;
					if (remNext == 11'h000)
						stateNext = shortReg ? ST_EOP : ST_IDLE;
				end
			end
			ST_EOP:
			begin
				cmdNext      = CMD_EOP;
				cmdValidNext = 1'b1;
				stateNext    = ST_CMD;
			end
			ST_CMD:
				stateNext = ST_IDLE;
			default:
				stateNext = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			stateReg    <= ST_IDLE;
			mpsReg      <= SIZE_RESET;
			hwSizeReg   <= SIZE_RESET;
			directReg   <= 1'b0;
			remReg      <= 11'h000;
			shortReg    <= 1'b0;
			cmdReg      <= CMD_NONE;
			cmdValidReg <= 1'b0;
			cfgWrReg    <= 1'b0;
			cfgDualReg  <= 1'b0;
			cfgIsoReg   <= 1'b0;
			wrReg       <= 1'b0;
			beReg       <= 2'h0;
			dataReg     <= 16'h0000;
		end
		else if (ce)
		begin
			stateReg    <= stateNext;
			mpsReg      <= mpsNext;
			hwSizeReg   <= hwSizeNext;
			directReg   <= directNext;
			remReg      <= remNext;
			shortReg    <= shortNext;
			cmdReg      <= cmdNext;
			cmdValidReg <= cmdValidNext;
			cfgWrReg    <= cfgWrNext;
			cfgDualReg  <= cfgDualNext;
			cfgIsoReg   <= cfgIsoNext;
			wrReg       <= wrNext;
			beReg       <= beNext;
			dataReg     <= dataNext;
		end
	end

	assign link.cfgWrite   = cfgWrReg;
	assign link.cfgMaxSize = hwSizeReg;
	assign link.cfgDirect  = directReg;
	assign link.cfgDual    = cfgDualReg;
	assign link.cfgTx      = 1'b1;
	assign link.cfgIso     = cfgIsoReg;
	assign link.cbWrite    = wrReg && !directReg;
	assign link.cbData     = dataReg;
	assign link.commonBusByteEnable       = directReg ? 2'h0 : beReg;
	assign link.dpWrite    = wrReg && directReg;
	assign link.dpData     = dataReg;
	assign link.directPortWriteByteEnable = directReg ? beReg : 2'h0;
	assign link.cmdValid   = cmdValidReg;
	assign link.cmdCode    = cmdReg;
	assign busy           = (stateReg != ST_IDLE) || wrReg || cmdValidReg;
	assign descriptorSize = mpsReg;

endmodule
